/* File: cpx_pkg.sv */
/*
  constants, register map, field positions and state encoding of the
  coprocessor transfer execution block.
  assumes a 32-bit instruction word and a 32-bit register bus.
*/
package cpx_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_PC = 8'h04;
    localparam logic [7:0] OFF_BASE = 8'h08;
    localparam logic [7:0] OFF_SRC = 8'h0c;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_ADDR = 8'h1c;
    localparam logic [7:0] OFF_RESULT = 8'h20;
    localparam logic [7:0] OFF_DEST = 8'h24;

    // instruction field positions
    localparam int F_COND = 28;
    localparam int F_FMT = 25;
    localparam int F_MVFMT = 24;
    localparam int F_P = 24;
    localparam int F_U = 23;
    localparam int F_N = 22;
    localparam int F_W = 21;
    localparam int F_L = 20;
    localparam int F_RN = 16;
    localparam int F_RD = 12;
    localparam int F_UNIT = 8;
    localparam int F_MOVE = 4;
    localparam int F_OFF = 0;

    // control register fields
    localparam int C_EMUL = 0;
    localparam int C_CNT = 8;
    localparam int C_ABEN = 16;
    localparam int C_ABAT = 20;

    // status register fields
    localparam int S_BUSY = 0;
    localparam int S_DONE = 1;
    localparam int S_UNDEF = 2;
    localparam int S_ABORT = 3;
    localparam int S_WB = 4;

    // flag nibble position in the flags register and the moved word (n z c v)
    localparam int FLAG_LSB = 28;

    // encodings and fixed values
    localparam logic [2:0] MEM_FMT = 3'h6;
    localparam logic [3:0] MOVE_FMT = 4'he;
    localparam logic [3:0] UNIT_CFG = 4'hf;
    localparam logic [3:0] PC_REG = 4'hf;
    localparam logic [31:0] PC_BASE_ADJ = 32'h0000_0008;
    localparam logic [31:0] PC_SRC_ADJ = 32'h0000_000c;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [4:0] CNT_RST = 5'h10;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_MV1 = 5'b00010,
        ST_MV2 = 5'b00100,
        ST_MV3 = 5'b01000,
        ST_XFER = 5'b10000
    } cpx_state_t;

endpackage

/* File: cpx_cfg_if.sv */
/*
  port between the execution block and its configuration register store.
  assumes one clock; read data arrive one edge after the index.
*/
interface cpx_cfg_if;
    logic we;
    logic [3:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctl (output we, output idx, output wdata, input rdata);
    modport mem (input we, input idx, input wdata, output rdata);
endinterface

/* File: cpx_cfg_mem.sv */
/*
  sixteen-word configuration register store of the internal unit.
  assumes a synchronous active-low reset; contents are not reset.
*/
module cpx_cfg_mem (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // access port
    cpx_cfg_if.mem port
);
    logic [31:0] mem_ff [16];
    logic [31:0] rdata_ff;

    always_ff @(posedge aclk) begin
        if (port.we) begin
            mem_ff[port.idx] <= port.wdata;
        end
    end

    // read data come from a register: one edge of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= cpx_pkg::ZERO_WORD;
        end else begin
            rdata_ff <= mem_ff[port.idx];
        end
    end

    assign port.rdata = rdata_ff;
endmodule // cpx_cfg_mem

/* File: cpx_addr_gen.sv */
/*
  address arithmetic for memory transfers: base choice, word-scaled offset,
  pre/post index selection.
  assumes the caller holds all inputs steady while it uses the outputs.
*/
module cpx_addr_gen (
    // operands
    input wire logic [31:0] base_val,
    input wire logic [31:0] pc_val,
    input wire logic [3:0] rn,
    input wire logic [7:0] off8,
    // mode bits
    input wire logic up,
    input wire logic pre,
    // results
    output logic [31:0] start_addr,
    output logic [31:0] wb_val
);
    wire [31:0] base_eff;
    wire [31:0] off_bytes;

    // base from pc reads pc+8 because of the pipeline
    assign base_eff = (rn == cpx_pkg::PC_REG)
        ? pc_val + cpx_pkg::PC_BASE_ADJ : base_val;
    // 8-bit word count, scaled to bytes
    assign off_bytes = {22'h00_0000, off8, 2'h0};
    assign wb_val = up ? base_eff + off_bytes : base_eff - off_bytes;
    assign start_addr = pre ? wb_val : base_eff;
endmodule // cpx_addr_gen

/* File: cpx_transfer_exec.sv */
/*
  coprocessor transfer execution block with an axi4-lite register port.
  software writes pc, base, source and flags, then the instruction word;
  the block evaluates the condition and runs the instruction.
  assumes a single clock, synchronous active-low reset and a well-behaved
  axi4-lite master with one write and one read outstanding at most.
*/
// How it works
// - memory transfer offset is an 8-bit word count, not bytes
// - offset shifted left two, added when sign set, else subtracted
// - pre-index uses modified base as address, post-index the old one
// - modified base written back only when base_update is set
// - post-indexed transfers never write back implicitly
// - first word at computed address, each further word four higher
// - low two address bits go out unchanged
// - base from program counter reads instruction address plus 8
// - abort takes data trap, still writes back base, keeps the rest
// - register move to a unit other than 15 takes undefined trap
// - instruction runs only when its condition holds
// - move to pc copies word bits 31..28 into n z c v only
// - move from pc sends instruction address plus 12
// - move with the internal unit takes three internal cycles
// - direction bit 1 is unit to core, 0 core to unit
// - every memory load or store to a unit takes undefined trap
module cpx_transfer_exec (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // transfer address towards the memory system
    output logic [31:0] xfer_addr,
    output logic xfer_valid,
    output logic xfer_load,
    // traps and state
    output logic undef_trap,
    output logic abort_trap,
    output logic busy
);
    // byte-lane merge used by every writable register
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // condition field against n z c v
    function automatic logic cond_pass(
        input logic [3:0] cond,
        input logic [3:0] nzcv
    );
        logic n;
        logic z;
        logic c;
        logic v;
        logic r;
        n = nzcv[3];
        z = nzcv[2];
        c = nzcv[1];
        v = nzcv[0];
        case (cond)
            4'h0: r = z;
            4'h1: r = !z;
            4'h2: r = c;
            4'h3: r = !c;
            4'h4: r = n;
            4'h5: r = !n;
            4'h6: r = v;
            4'h7: r = !v;
            4'h8: r = c && !z;
            4'h9: r = !c || z;
            4'ha: r = (n == v);
            4'hb: r = (n != v);
            4'hc: r = !z && (n == v);
            4'hd: r = z || (n != v);
            4'he: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // bus state
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] aw_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    // software registers
    logic [31:0] instr_ff;
    logic [31:0] pc_ff;
    logic [31:0] base_ff;
    logic [31:0] src_ff;
    logic [3:0] flags_ff;
    logic emul_ff;
    logic [4:0] cnt_ff;
    logic aben_ff;
    logic [3:0] abat_ff;
    // execution state
    cpx_pkg::cpx_state_t state_ff;
    logic go_ff;
    logic done_ff;
    logic undef_ff;
    logic abort_ff;
    logic wb_ff;
    logic [31:0] cur_ff;
    logic [4:0] idx_ff;
    logic [4:0] nwords_ff;
    logic [31:0] result_ff;
    logic [3:0] dest_ff;
    logic [31:0] xfer_addr_ff;
    logic xfer_valid_ff;
    logic xfer_load_ff;
    logic undef_trap_ff;
    logic abort_trap_ff;
    logic busy_ff;

    cpx_cfg_if cfg ();

    // write side decode
    wire wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    wire sel_instr = wr_fire && (aw_ff == cpx_pkg::OFF_INSTR);
    wire sel_pc = wr_fire && (aw_ff == cpx_pkg::OFF_PC);
    wire sel_base = wr_fire && (aw_ff == cpx_pkg::OFF_BASE);
    wire sel_src = wr_fire && (aw_ff == cpx_pkg::OFF_SRC);
    wire sel_flags = wr_fire && (aw_ff == cpx_pkg::OFF_FLAGS);
    wire sel_ctrl = wr_fire && (aw_ff == cpx_pkg::OFF_CTRL);
    wire wr_ro = (aw_ff == cpx_pkg::OFF_STATUS)
        || (aw_ff == cpx_pkg::OFF_ADDR)
        || (aw_ff == cpx_pkg::OFF_RESULT)
        || (aw_ff == cpx_pkg::OFF_DEST);
    wire wr_map = sel_instr || sel_pc || sel_base || sel_src
        || sel_flags || sel_ctrl || wr_ro;
    wire [31:0] instr_wr = merge_strb(instr_ff, wd_ff, ws_ff);
    wire [31:0] ctrl_val = {8'h00, abat_ff, 3'h0, aben_ff, 3'h0, cnt_ff,
        7'h00, emul_ff};
    wire [31:0] ctrl_wr = merge_strb(ctrl_val, wd_ff, ws_ff);
    wire [31:0] flags_val = {flags_ff, 28'h000_0000};
    wire [31:0] flags_wr = merge_strb(flags_val, wd_ff, ws_ff);

    // instruction fields
    wire [3:0] f_cond = instr_ff[cpx_pkg::F_COND +: 4];
    wire [3:0] f_rn = instr_ff[cpx_pkg::F_RN +: 4];
    wire [3:0] f_rd = instr_ff[cpx_pkg::F_RD +: 4];
    wire [3:0] f_unit = instr_ff[cpx_pkg::F_UNIT +: 4];
    wire f_load = instr_ff[cpx_pkg::F_L];
    wire f_wb = instr_ff[cpx_pkg::F_W];
    wire is_mem = instr_ff[cpx_pkg::F_FMT +: 3] == cpx_pkg::MEM_FMT;
    wire is_move = (instr_ff[cpx_pkg::F_MVFMT +: 4] == cpx_pkg::MOVE_FMT)
        && instr_ff[cpx_pkg::F_MOVE];

    // dispatch decisions, taken on the cycle after the instruction write
    wire go_ok = go_ff && cond_pass(f_cond, flags_ff);
    wire mv_ok = go_ok && is_move && (f_unit == cpx_pkg::UNIT_CFG);
    wire xf_start = go_ok && is_mem && emul_ff;
    // memory transfers and foreign-unit moves are left to the trap handler
    wire take_undef = go_ok && !mv_ok;
    wire in_x = state_ff == cpx_pkg::ST_XFER;
    wire abort_hit = in_x && aben_ff && (idx_ff == {1'b0, abat_ff});
    wire x_last = in_x && (idx_ff == 5'(nwords_ff - 5'h01));
    wire x_end = abort_hit || x_last;
    wire mv_commit = state_ff == cpx_pkg::ST_MV3;
    wire finish = (go_ff && !mv_ok && !xf_start) || x_end || mv_commit;
    // write-back only on request, also after an abort
    wire do_wb = x_end && f_wb;

    wire [31:0] start_addr;
    wire [31:0] wb_val;

    cpx_addr_gen u_addr (
        .base_val(base_ff),
        .pc_val(pc_ff),
        .rn(f_rn),
        .off8(instr_ff[cpx_pkg::F_OFF +: 8]),
        .up(instr_ff[cpx_pkg::F_U]),
        .pre(instr_ff[cpx_pkg::F_P]),
        .start_addr(start_addr),
        .wb_val(wb_val)
    );

    cpx_cfg_mem u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(cfg.mem)
    );

    // core-to-unit value; pc source reads instruction address plus 12
    wire [31:0] mv_src = (f_rd == cpx_pkg::PC_REG)
        ? pc_ff + cpx_pkg::PC_SRC_ADJ : src_ff;
    assign cfg.idx = instr_ff[cpx_pkg::F_RN +: 4];
    assign cfg.wdata = mv_src;
    assign cfg.we = mv_commit && !f_load;

    // read side decode
    wire [31:0] status_val = {27'h000_0000, wb_ff, abort_ff, undef_ff,
        done_ff, busy_ff};
    wire [31:0] rd_val =
        (araddr == cpx_pkg::OFF_INSTR) ? instr_ff :
        (araddr == cpx_pkg::OFF_PC) ? pc_ff :
        (araddr == cpx_pkg::OFF_BASE) ? base_ff :
        (araddr == cpx_pkg::OFF_SRC) ? src_ff :
        (araddr == cpx_pkg::OFF_FLAGS) ? flags_val :
        (araddr == cpx_pkg::OFF_CTRL) ? ctrl_val :
        (araddr == cpx_pkg::OFF_STATUS) ? status_val :
        (araddr == cpx_pkg::OFF_ADDR) ? xfer_addr_ff :
        (araddr == cpx_pkg::OFF_RESULT) ? result_ff :
        (araddr == cpx_pkg::OFF_DEST) ? {28'h000_0000, dest_ff} :
        cpx_pkg::ZERO_WORD;
    wire rd_map = (araddr[1:0] == 2'h0) && (araddr <= cpx_pkg::OFF_DEST);

    // write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= cpx_pkg::RESP_OK;
            aw_ff <= 8'h00;
            wd_ff <= cpx_pkg::ZERO_WORD;
            ws_ff <= 4'h0;
        end else begin
            if (awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                aw_ff <= awaddr;
            end
            if (wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wd_ff <= wdata;
                ws_ff <= wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_map ? cpx_pkg::RESP_OK : cpx_pkg::RESP_ERR;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read channel: answer one edge after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= cpx_pkg::ZERO_WORD;
            rresp_ff <= cpx_pkg::RESP_OK;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_map ? rd_val : cpx_pkg::ZERO_WORD;
            rresp_ff <= rd_map ? cpx_pkg::RESP_OK : cpx_pkg::RESP_ERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // software registers; hardware updates win over a colliding write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_ff <= cpx_pkg::ZERO_WORD;
            pc_ff <= cpx_pkg::ZERO_WORD;
            base_ff <= cpx_pkg::ZERO_WORD;
            src_ff <= cpx_pkg::ZERO_WORD;
            flags_ff <= cpx_pkg::FLAGS_RST;
            emul_ff <= 1'b0;
            cnt_ff <= cpx_pkg::CNT_RST;
            aben_ff <= 1'b0;
            abat_ff <= 4'h0;
        end else begin
            // a new instruction is refused while one is running
            if (sel_instr && !busy_ff) begin
                instr_ff <= instr_wr;
            end
            if (sel_pc) begin
                pc_ff <= merge_strb(pc_ff, wd_ff, ws_ff);
            end
            if (do_wb) begin
                base_ff <= wb_val;
            end else if (sel_base) begin
                base_ff <= merge_strb(base_ff, wd_ff, ws_ff);
            end
            if (sel_src) begin
                src_ff <= merge_strb(src_ff, wd_ff, ws_ff);
            end
            if (mv_commit && f_load && (f_rd == cpx_pkg::PC_REG)) begin
                flags_ff <= cfg.rdata[cpx_pkg::FLAG_LSB +: 4];
            end else if (sel_flags) begin
                flags_ff <= flags_wr[cpx_pkg::FLAG_LSB +: 4];
            end
            if (sel_ctrl) begin
                emul_ff <= ctrl_wr[cpx_pkg::C_EMUL];
                cnt_ff <= ctrl_wr[cpx_pkg::C_CNT +: 5];
                aben_ff <= ctrl_wr[cpx_pkg::C_ABEN];
                abat_ff <= ctrl_wr[cpx_pkg::C_ABAT +: 4];
            end
        end
    end

    // sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= cpx_pkg::ST_IDLE;
            go_ff <= 1'b0;
            cur_ff <= cpx_pkg::ZERO_WORD;
            idx_ff <= 5'h00;
            nwords_ff <= 5'h01;
        end else begin
            go_ff <= sel_instr && !busy_ff;
            case (state_ff)
                cpx_pkg::ST_IDLE: begin
                    if (mv_ok) begin
                        state_ff <= cpx_pkg::ST_MV1;
                    end else if (xf_start) begin
                        state_ff <= cpx_pkg::ST_XFER;
                        cur_ff <= start_addr;
                        idx_ff <= 5'h00;
                        // size flag: one word or the unit's full set
                        nwords_ff <= instr_ff[cpx_pkg::F_N]
                            ? cnt_ff : 5'h01;
                    end
                end
                cpx_pkg::ST_MV1: state_ff <= cpx_pkg::ST_MV2;
                cpx_pkg::ST_MV2: state_ff <= cpx_pkg::ST_MV3;
                cpx_pkg::ST_MV3: state_ff <= cpx_pkg::ST_IDLE;
                cpx_pkg::ST_XFER: begin
                    if (x_end) begin
                        state_ff <= cpx_pkg::ST_IDLE;
                    end else begin
                        cur_ff <= cur_ff + cpx_pkg::WORD_STEP;
                        idx_ff <= 5'(idx_ff + 5'h01);
                    end
                end
                default: state_ff <= cpx_pkg::ST_IDLE;
            endcase
        end
    end

    // results, sticky status and outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_ff <= 1'b0;
            undef_ff <= 1'b0;
            abort_ff <= 1'b0;
            wb_ff <= 1'b0;
            result_ff <= cpx_pkg::ZERO_WORD;
            dest_ff <= 4'h0;
            xfer_addr_ff <= cpx_pkg::ZERO_WORD;
            xfer_valid_ff <= 1'b0;
            xfer_load_ff <= 1'b0;
            undef_trap_ff <= 1'b0;
            abort_trap_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (sel_instr && !busy_ff)
                || (busy_ff && !finish);
            // flags of the previous instruction clear as a new one starts
            if (go_ff) begin
                done_ff <= 1'b0;
                undef_ff <= take_undef;
                abort_ff <= 1'b0;
                wb_ff <= 1'b0;
            end
            if (finish) begin
                done_ff <= 1'b1;
            end
            if (abort_hit) begin
                abort_ff <= 1'b1;
            end
            if (do_wb) begin
                wb_ff <= 1'b1;
            end
            undef_trap_ff <= take_undef;
            abort_trap_ff <= abort_hit;
            // address lines carry all 32 bits, low two untouched
            xfer_valid_ff <= in_x;
            if (in_x) begin
                xfer_addr_ff <= cur_ff;
                xfer_load_ff <= f_load;
            end
            if (mv_commit && f_load && (f_rd != cpx_pkg::PC_REG)) begin
                result_ff <= cfg.rdata;
                dest_ff <= f_rd;
            end
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign xfer_addr = xfer_addr_ff;
    assign xfer_valid = xfer_valid_ff;
    assign xfer_load = xfer_load_ff;
    assign undef_trap = undef_trap_ff;
    assign abort_trap = abort_trap_ff;
    assign busy = busy_ff;
endmodule // cpx_transfer_exec

/* File: cpx_checker.sv */
/* port timing checks for cpx_transfer_exec.
   assumes binding to the top module ports only. */
module cpx_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // transfer port and traps
    input wire logic [31:0] xfer_addr,
    input wire logic xfer_valid,
    input wire logic undef_trap,
    input wire logic abort_trap,
    input wire logic busy
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_two_words;
        xfer_valid ##1 xfer_valid;
    endsequence
    a_word_step: assert property (s_two_words |->
        xfer_addr == $past(xfer_addr) + 32'h0000_0004) else $error("step");
    a_undef_pulse: assert property (undef_trap |=> !undef_trap)
        else $error("undef pulse");
    a_abort_pulse: assert property (abort_trap |=> !abort_trap)
        else $error("abort pulse");
    // wide bound: a full set of 32 words must still end
    a_busy_ends: assert property ($rose(busy) |-> ##[1:60] !busy)
        else $error("busy stuck");
    a_word_busy: assert property (xfer_valid |-> $past(busy))
        else $error("word idle");
    a_read_turn: assert property (arvalid && arready |=> rvalid)
        else $error("read late");
    a_write_turn: assert property (awvalid && awready && wvalid && wready
        |-> ##[1:2] bvalid) else $error("write late");
    a_read_hold: assert property (rvalid && !rready |=> rvalid)
        else $error("rvalid drop");
    a_write_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid drop");
endmodule // cpx_checker

bind cpx_transfer_exec cpx_checker chk_i (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .xfer_addr(xfer_addr),
    .xfer_valid(xfer_valid), .undef_trap(undef_trap),
    .abort_trap(abort_trap), .busy(busy));

/* File: cpx_mem_model.sv */
/* memory side of the transfer port: counts words, keeps last address.
   assumes one clock; it never stalls, the port has no ready. */
module cpx_mem_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // transfer port
    input wire logic [31:0] xfer_addr,
    input wire logic xfer_valid,
    // log
    output logic [7:0] words_ff,
    output logic [31:0] last_ff
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            words_ff <= 8'h00;
            last_ff <= 32'h0000_0000;
        end else if (xfer_valid) begin
            words_ff <= words_ff + 8'h01;
            last_ff <= xfer_addr;
        end
    end
endmodule // cpx_mem_model

/* File: test_cpx_transfer_exec.sv */
/* self-checking bench for cpx_transfer_exec over its register bus.
   assumes the checker file is compiled alongside. */
module test_cpx_transfer_exec;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
    logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, ld = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, words;
    logic [31:0] wdata = 32'h0000_0000, rdata, xfer_addr, last, v;
    logic awready, wready, bvalid, arready, rvalid, xfer_valid, xfer_load;
    logic undef_trap, abort_trap, busy;
    logic [1:0] bresp, rresp, bs, rs;
    int err_total = 0, cmp_count = 0;
    always #4 aclk = ~aclk;
    always @(posedge aclk) if (xfer_valid) ld <= xfer_load;
    cpx_transfer_exec dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .xfer_addr, .xfer_valid, .xfer_load, .undef_trap, .abort_trap, .busy);
    cpx_mem_model mm (.aclk, .aresetn, .xfer_addr, .xfer_valid,
        .words_ff(words), .last_ff(last));
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bs = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        v = rdata;
        rs = rresp;
    endtask
    task automatic rc(string n, logic [7:0] a, logic [31:0] m, e);
        rd(a);
        chk(n, e, v & m);
    endtask
    // poll done up to 40 reads; a lost completion fails the done check
    task automatic go(input logic [31:0] i);
        int k;
        wr(8'h00, i);
        k = 0;
        do begin
            rd(8'h18);
            k++;
        end while (v[1] !== 1'h1 && k < 40);
        chk("done", 32'h0000_0002, v & 32'h0000_0002);
    endtask
    function automatic logic [31:0] mem(logic [4:0] b, logic [3:0] rn,
        logic [7:0] off);
        return {4'he, 3'h6, b, rn, 4'h1, 4'h5, off};
    endfunction
    function automatic logic [31:0] mov(logic [3:0] c, logic l,
        logic [3:0] rd_f, u, first_reg_field);
        return {c, 4'he, 3'h0, l, first_reg_field, rd_f, u, 3'h0, 1'h1, 4'h0};
    endfunction
    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        wr(8'h14, 32'h0000_0201);
        wr(8'h08, 32'h1000_0002);
        go(mem(5'b11011, 4'h1, 8'h03));
        rc("addr", 8'h1c, ALL, 32'h1000_000e);
        rc("base", 8'h08, ALL, 32'h1000_000e);
        rc("undef", 8'h18, 32'h0000_0004, 32'h0000_0004);
        chk("load", 32'h0000_0001, {31'h0000_0000, ld});
        wr(8'h08, 32'h0000_2000);
        go(mem(5'b00100, 4'h1, 8'h01));
        rc("addr", 8'h1c, ALL, 32'h0000_2004);
        rc("base", 8'h08, ALL, 32'h0000_2000);
        chk("words", 32'h0000_0003, {24'h00_0000, words});
        chk("last", 32'h0000_2004, last);
        wr(8'h04, 32'h0000_0100);
        go(mem(5'b11001, 4'hf, 8'h00));
        rc("addr", 8'h1c, ALL, 32'h0000_0108);
        wr(8'h14, 32'h0011_0301);
        wr(8'h08, 32'h0000_3000);
        go(mem(5'b10111, 4'h1, 8'h02));
        rc("abort", 8'h18, 32'h0000_0008, 32'h0000_0008);
        rc("base", 8'h08, ALL, 32'h0000_2ff8);
        wr(8'h14, 32'h0000_0301);
        go(mem(5'b10111, 4'h1, 8'h02));
        rc("retry", 8'h08, ALL, 32'h0000_2ff0);
        wr(8'h0c, 32'ha5a5_1234);
        go(mov(4'he, 1'h0, 4'h2, 4'hf, 4'h3));
        go(mov(4'he, 1'h1, 4'h4, 4'hf, 4'h3));
        rc("result", 8'h20, ALL, 32'ha5a5_1234);
        rc("dest", 8'h24, 32'h0000_000f, 32'h0000_0004);
        wr(8'h04, 32'h0000_0200);
        go(mov(4'he, 1'h0, 4'hf, 4'hf, 4'h4));
        go(mov(4'he, 1'h1, 4'h1, 4'hf, 4'h4));
        rc("result", 8'h20, ALL, 32'h0000_020c);
        wr(8'h0c, 32'h9000_0000);
        go(mov(4'he, 1'h0, 4'h2, 4'hf, 4'h5));
        go(mov(4'he, 1'h1, 4'hf, 4'hf, 4'h5));
        rc("flags", 8'h10, ALL, 32'h9000_0000);
        rc("pc", 8'h04, ALL, 32'h0000_0200);
        go(mov(4'he, 1'h1, 4'h2, 4'h3, 4'h3));
        rc("undef", 8'h18, 32'h0000_0004, 32'h0000_0004);
        go(mov(4'h0, 1'h1, 4'hf, 4'hf, 4'h3));
        rc("flags", 8'h10, ALL, 32'h9000_0000);
        rc("unmapped", 8'h40, ALL, 32'h0000_0000);
        chk("rresp", 32'h0000_0002, {30'h0000_0000, rs});
        wr(8'h40, ALL);
        chk("bresp", 32'h0000_0002, {30'h0000_0000, bs});
        stop_test;
    end
endmodule // test_cpx_transfer_exec
